// file: rtl/retire_progress_timeout_watchdog.sv
// Purpose: retirement progress watchdog with machine-check flag
// Assumes: event inputs come from core logic on sys_clk_i
// Notes:   flag is sticky until status clear or reset
//
// Behaviour
// RQ1 - base counter is 15 bits; carry out of top bit declares a time-out.
// RQ2 - alternative variant uses 23 bits, carry from bit 22; width is a parameter.
// RQ3 - any micro-instruction retirement clears the counter to zero.
// RQ4 - exception, reset or bus-init event also clear the counter.
// RQ5 - a time-out sets bit 38 of the machine-check bank status.
// RQ6 - counter increments by one each cycle without a clearing condition.
`timescale 1ns/1ps
module retire_progress_timeout_watchdog #(
    parameter int unsigned CNT_WIDTH = retire_wdt_pkg::BASE_CNT_WIDTH
) (
    // clock and reset
    input  wire logic        sys_clk_i,
    input  wire logic        sys_rst_i,
    // core events
    input  wire logic        retire_i,
    input  wire logic        exception_i,
    input  wire logic        bus_init_event_i,
    // status clear from machine-check logic
    input  wire logic        status_clear_i,
    // outputs
    output logic             timeout_pulse_o,
    output logic             retire_timeout_flag_o,
    output logic [63:0]      machine_check_bank_status_o
);
    retire_wdt_if wdt ();

    logic        flag;
    logic        timeout_q;
    logic        next_flag;

    // ------------------------------------------------------------------
    // clearing conditions
    // ------------------------------------------------------------------
    assign wdt.clear = retire_i || exception_i || bus_init_event_i; // see RQ3 see RQ4

    retire_progress_counter #(
        .CNT_WIDTH (CNT_WIDTH)
    ) u_counter (
        .sys_clk_i (sys_clk_i),
        .sys_rst_i (sys_rst_i),
        .wdt       (wdt)
    );

    // ------------------------------------------------------------------
    // sticky flag, set wins over clear
    // ------------------------------------------------------------------
    assign next_flag = wdt.carry || (flag && !status_clear_i); // see RQ5

    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            flag      <= 1'b0;
            timeout_q <= 1'b0;
        end else begin
            flag      <= next_flag;
            timeout_q <= wdt.carry;
        end
    end

    assign timeout_pulse_o       = timeout_q;
    assign retire_timeout_flag_o = flag;

    always_comb begin
        machine_check_bank_status_o = retire_wdt_pkg::STATUS_RESET_VALUE;
        machine_check_bank_status_o[retire_wdt_pkg::TIMEOUT_FLAG_BIT] = flag; // see RQ5
    end

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    property p_flag_set;
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        wdt.carry |=> machine_check_bank_status_o[retire_wdt_pkg::TIMEOUT_FLAG_BIT]
                      && timeout_pulse_o;
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("time-out flag not set"); // see RQ5

    property p_flag_hold;
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        (flag && !status_clear_i) |=> flag;
    endproperty
    a_flag_hold: assert property (p_flag_hold) else $error("flag dropped"); // see RQ5

    property p_flag_cause;
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        $rose(flag) |-> $past(wdt.carry);
    endproperty
    a_flag_cause: assert property (p_flag_cause) else $error("flag without carry"); // see RQ1

    property p_clear_no_carry;
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        (retire_i || exception_i || bus_init_event_i) |-> !wdt.carry;
    endproperty
    a_clear_no_carry: assert property (p_clear_no_carry) else $error("carry on clear"); // see RQ4

    property p_pulse_single;
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        (timeout_pulse_o && !wdt.carry) |=> !timeout_pulse_o;
    endproperty
    a_pulse_single: assert property (p_pulse_single) else $error("pulse too long"); // see RQ1

    property p_pulse_flag;
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        timeout_pulse_o |-> retire_timeout_flag_o;
    endproperty
    a_pulse_flag: assert property (p_pulse_flag) else $error("pulse without flag"); // see RQ5

    property p_flag_release;
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        (status_clear_i && !wdt.carry) |=> !flag;
    endproperty
    a_flag_release: assert property (p_flag_release) else $error("flag not cleared"); // see RQ5

    property p_status_only_flag;
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        (machine_check_bank_status_o
            & ~(64'h0000_0000_0000_0001 << retire_wdt_pkg::TIMEOUT_FLAG_BIT)) == '0;
    endproperty
    a_status_only_flag: assert property (p_status_only_flag) else $error("stray status bit"); // see RQ5
endmodule : retire_progress_timeout_watchdog

// file: rtl/retire_wdt_pkg.sv
// Purpose: shared constants for the retirement progress watchdog
// Assumes: single core clock, asynchronous active-high reset
// Notes:   counter width selects base or alternative variant
package retire_wdt_pkg;
    // ------------------------------------------------------------------
    // counter widths
    // ------------------------------------------------------------------
    localparam int unsigned BASE_CNT_WIDTH = 15;
    localparam int unsigned ALT_CNT_WIDTH  = 23;
    // ------------------------------------------------------------------
    // status layout
    // ------------------------------------------------------------------
    localparam int unsigned STATUS_WIDTH        = 64;
    localparam int unsigned TIMEOUT_FLAG_BIT    = 38;
    localparam logic [63:0] STATUS_RESET_VALUE  = 64'h0000_0000_0000_0000;
endpackage : retire_wdt_pkg

// file: rtl/retire_wdt_if.sv
// Purpose: carrier between watchdog top and its progress counter
// Assumes: one clock domain
// Notes:   clear request in, carry pulse out
`timescale 1ns/1ps
interface retire_wdt_if;
    logic clear;
    logic carry;
    modport ctl (output clear, input  carry);
    modport cnt (input  clear, output carry);
endinterface : retire_wdt_if

// file: rtl/retire_progress_counter.sv
// Purpose: progress counter that reports carry out of its top bit
// Assumes: clear is synchronous to sys_clk_i
// Notes:   width is a parameter, wraps to zero after carry
`timescale 1ns/1ps
module retire_progress_counter #(
    parameter int unsigned CNT_WIDTH = retire_wdt_pkg::BASE_CNT_WIDTH
) (
    // clock and reset
    input  wire logic      sys_clk_i,
    input  wire logic      sys_rst_i,
    // control
    retire_wdt_if.cnt      wdt
);
    logic [CNT_WIDTH-1:0] count;
    logic [CNT_WIDTH:0]   sum;

    // ------------------------------------------------------------------
    // counting
    // ------------------------------------------------------------------
    assign sum       = {1'b0, count} + {{CNT_WIDTH{1'b0}}, 1'b1};
    assign wdt.carry = !wdt.clear && sum[CNT_WIDTH]; // see RQ1 see RQ2

    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            count <= '0;
        end else if (wdt.clear) begin
            count <= '0; // see RQ3 see RQ4
        end else begin
            count <= sum[CNT_WIDTH-1:0]; // see RQ6
        end
    end

    property p_cnt_clear;
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        wdt.clear |=> (count == '0);
    endproperty
    a_cnt_clear: assert property (p_cnt_clear) else $error("count not cleared"); // see RQ3

    property p_cnt_step;
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        !wdt.clear |=> (count == $past(count) + 1'b1);
    endproperty
    a_cnt_step: assert property (p_cnt_step) else $error("count did not step"); // see RQ6

    property p_carry_top;
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        wdt.carry |-> (&count) ##1 (count == '0);
    endproperty
    a_carry_top: assert property (p_carry_top) else $error("carry not at top"); // see RQ1

    property p_carry_when_full;
        @(posedge sys_clk_i) disable iff (sys_rst_i)
        (&count && !wdt.clear) |-> wdt.carry;
    endproperty
    a_carry_when_full: assert property (p_carry_when_full) else $error("carry missed"); // see RQ2
endmodule : retire_progress_counter

// file: dv/tb_top.sv
// Purpose: self-checking bench for the retirement progress watchdog
// Assumes: CNT_WIDTH shortened to 4, so a time-out takes 16 idle edges
// Notes:   inputs change at the falling edge, outputs read there too
`timescale 1ns/1ps
module tb_top;
    localparam int unsigned W = 4;
    logic        sys_clk_i = 1'b0;
    logic        sys_rst_i = 1'b1;
    logic        retire_i = 1'b0;
    logic        exception_i = 1'b0;
    logic        bus_init_event_i = 1'b0;
    logic        status_clear_i = 1'b0;
    logic        pulse;
    logic        flag;
    logic [63:0] status;
    int          error_cnt = 0;
    int          samples_checked = 0;

    always #12.5 sys_clk_i = ~sys_clk_i;

    retire_progress_timeout_watchdog #(.CNT_WIDTH(W)) retire_progress_timeout_watchdog_inst (
        .sys_clk_i                  (sys_clk_i),
        .sys_rst_i                  (sys_rst_i),
        .retire_i                   (retire_i),
        .exception_i                (exception_i),
        .bus_init_event_i           (bus_init_event_i),
        .status_clear_i             (status_clear_i),
        .timeout_pulse_o            (pulse),
        .retire_timeout_flag_o      (flag),
        .machine_check_bank_status_o(status)
    );

    task check(input logic [63:0] seen, input logic [63:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    // n rising edges with the given events, ends at a falling edge
    task cyc(input logic [2:0] ev, input int n);
        repeat (n) begin
            {retire_i, exception_i, bus_init_event_i} = ev;
            @(negedge sys_clk_i);
        end
    endtask : cyc

    // from count zero: silent for 15 edges, time-out on the 16th
    task expect_timeout;
        cyc(3'h0, (1 << W) - 1);
        check(pulse, 1'b0);
        cyc(3'h0, 1);
        check(pulse, 1'b1);
        check(flag, 1'b1);
        check(status, 64'h0000_0040_0000_0000);
        cyc(3'h0, 1);
        check(pulse, 1'b0);
        check(flag, 1'b1);
    endtask : expect_timeout

    task t_each_clear;
        for (int i = 0; i < 3; i++) begin
            cyc(3'h0, 8);
            status_clear_i = 1'b1;
            cyc(3'h4 >> i, 1);
            status_clear_i = 1'b0;
            check(flag, 1'b0);
            expect_timeout();
        end
    endtask : t_each_clear

    // clear arriving in the carry cycle suppresses the time-out
    task t_clear_at_carry;
        cyc(3'h4, 1);
        cyc(3'h0, (1 << W) - 1);
        cyc(3'h4, 1);
        check(pulse, 1'b0);
        expect_timeout();
    endtask : t_clear_at_carry

    task t_mid_reset;
        cyc(3'h0, 9);
        sys_rst_i = 1'b1;
        cyc(3'h0, 2);
        check(status, 64'h0000_0000_0000_0000);
        sys_rst_i = 1'b0;
        expect_timeout();
    endtask : t_mid_reset

    // carry and status clear in one cycle: set wins
    task t_set_wins;
        cyc(3'h4, 1);
        cyc(3'h0, (1 << W) - 1);
        status_clear_i = 1'b1;
        cyc(3'h0, 1);
        status_clear_i = 1'b0;
        check(flag, 1'b1);
        check(pulse, 1'b1);
    endtask : t_set_wins

    task stop_test;
        $display("checks=%0d errors=%0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : stop_test

    initial begin
        repeat (10) @(negedge sys_clk_i);
        sys_rst_i = 1'b0;
        expect_timeout();
        t_each_clear();
        t_clear_at_carry();
        t_mid_reset();
        t_set_wins();
        stop_test();
    end
endmodule : tb_top
